// *** cei_chan_model.sv ***
// Channel-side model issuing strobes with coded groups
`timescale 1ns/1ns
module cei_chan_model (
    input  wire logic        clk_i,           // Equipment clock
    input  wire logic [3:0]  ans_i,           // Fault, end, refuse, ack
    input  wire logic [12:0] din_i,           // Equipment drive and parity
    output logic      [2:0]  stb_o = 3'h0,    // Word, order, select
    output logic      [11:0] dat_o = 12'hFFF, // Code or word
    output logic             par_o = 1'b0     // Parity bit
);
    // One strobe: raise, wait bounded for an answer, drop, await release
    task automatic xfer(input int k, input logic [11:0] c, input logic b,
                        input int lim, output logic [3:0] a,
                        output logic [12:0] got);
        int n;
        n = 0;
        a = 4'h0;
        @(negedge clk_i);
        dat_o = c;
        par_o = ~^c ^ b;
        stb_o = 3'(3'h1 << k);
        // Running out stands in for the internal refusal
        while (a == 4'h0 && n < lim) begin
            @(posedge clk_i);
            a = ans_i;
            got = din_i;
            n++;
        end
        @(negedge clk_i);
        stb_o = 3'h0;
        dat_o = ~c;                           // Released lines lose the code
        par_o = ~par_o;
        repeat (50) if (ans_i != 4'h0) @(negedge clk_i); // Await release
    endtask
endmodule

// *** cei_data_sync.sv ***
// Two-stage synchroniser for the data group and its parity bit
`timescale 1ns/1ns
module cei_data_sync #(
    parameter int W = 13                    // Data plus parity
) (
    // Clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         rstn_i,
    // Raw and synced group
    input  wire logic [W-1:0] raw_i,
    output logic      [W-1:0] sync_o
);
    import cei_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [W-1:0] s1;                   // First stage
        logic [W-1:0] s2;                   // Second stage
    } cei_dsync_t;

    cei_dsync_t st_q, st_d;

    // Shift the group through
    always_comb begin
        st_d    = st_q;
        st_d.s1 = raw_i;
        st_d.s2 = st_q.s1;
    end

    // Register the state
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_o = st_q.s2;
endmodule

// *** cei_equipment.sv ***
// Equipment end of the bidirectional channel interface
`timescale 1ns/1ns
module cei_equipment #(
    parameter int DW = 12                   // Data group width
) (
    // Clock and reset (reset is the global initialise)
    input  wire logic                   ref_clk_i,
    input  wire logic                   rstn_i,
    // Channel strobes and levels
    input  wire logic                   sel_strobe_i,
    input  wire logic                   ord_strobe_i,
    input  wire logic                   wrd_strobe_i,
    input  wire logic                   in_level_i,
    input  wire logic                   out_level_i,
    input  wire logic                   act_level_i,
    // Data lines and parity, three-signal form
    input  wire logic [DW-1:0]          data_in_i,
    input  wire logic                   par_in_i,
    output logic      [DW-1:0]          data_out_o,
    output logic                        par_out_o,
    output logic                        data_oe_o,
    // Answers to the channel
    output logic                        ack_o,
    output logic                        refuse_o,
    output logic                        record_end_signal_o,
    output logic                        par_fault_o,
    output logic [cei_pkg::CEI_STAT_W-1:0] status_o,
    output logic                        status_oe_o,
    // Equipment side
    input  wire logic [cei_pkg::CEI_EQ_W-1:0] eq_num_i,
    input  wire logic                   unavail_i,
    input  wire logic                   ready_i,
    input  wire logic                   ord_can_do_i,
    input  wire logic                   ord_redo_i,
    input  wire logic                   ord_done_i,
    input  wire logic [DW-1:0]          rd_word_i,
    input  wire logic                   rd_valid_i,
    input  wire logic                   rd_rec_end_i,
    input  wire logic [cei_pkg::CEI_STAT_W-1:0] dev_stat_i,
    output logic [DW-1:0]               ord_code_o,
    output logic                        ord_start_o,
    output logic [cei_pkg::CEI_UNIT_W-1:0] unit_o,
    output logic                        attached_o,
    output logic                        link_pfault_o,
    output logic                        busy_o,
    output logic                        rd_take_o,
    output logic [DW-1:0]               wr_word_o,
    output logic                        wr_strobe_o,
    output logic                        wr_rec_close_o,
    output logic                        rd_xfer_o
);
    import cei_pkg::*;

    // ************************************************************
    // Synchronisers
    // ************************************************************
    cei_sync_if sy ();
    logic [DW:0] grp_s;                     // Parity in the top bit

    cei_sync u_sync (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .raw_i     ({act_level_i, out_level_i, in_level_i,
                     wrd_strobe_i, ord_strobe_i, sel_strobe_i}),
        .sy        (sy)
    );

    cei_data_sync #(.W(DW + 1)) u_dsync (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .raw_i     ({par_in_i, data_in_i}),
        .sync_o    (grp_s)
    );

    // Odd parity check on a group plus its parity bit
    function automatic logic par_ok(input logic [CEI_GRP_W:0] g);
        par_ok = ^g;
    endfunction

    // Parity bit that makes the group odd
    function automatic logic par_gen(input logic [CEI_GRP_W-1:0] w);
        par_gen = ~(^w);
    endfunction

    // ************************************************************
    // State record
    // ************************************************************
    typedef struct packed {
        cei_state_t          st;            // Handshake state
        cei_ans_t            ans;           // Answer being held
        logic [2:0]          ans_hot;       // Answer lines: end, refuse, ack
        logic [CEI_CNT_W-1:0] cnt;          // Select hold-off counter
        logic                attached;      // Attached to the channel
        logic                stat_gate;     // Status lines gated
        logic                pfault;        // Link parity fault flag
        logic                pf_out;        // Parity fault to channel
        logic                ord_lock;      // Order pending
        logic [DW-1:0]       ord_code;      // Last accepted order
        logic                ord_start;     // One-cycle order start
        logic                busy;          // Busy status
        logic                rec_skip;      // Input waits for next record
        logic                rec_end_pend;  // Record ended, report once
        logic                rd_xfer;       // Input transfer active
        logic                wr_xfer;       // Output transfer active
        logic [DW-1:0]       dout;          // Driven word
        logic                pout;          // Driven parity
        logic                oe;            // Data drive enable
        logic                rd_take;       // Word taken pulse
        logic [DW-1:0]       wr_word;       // Sampled output word
        logic                wr_stb;        // Output word pulse
        logic                wr_close;      // Record close pulse
        logic [CEI_UNIT_W-1:0] unit;        // Selected unit
        logic [CEI_STAT_W-1:0] status;      // Gated status
    } cei_eq_t;

    cei_eq_t q, d;
    logic    match;                         // Select names this equipment
    logic    sel_par;                       // Select code parity good
    logic    ord_par;                       // Order/data parity good

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        d           = q;
        d.ord_start = 1'b0;
        d.rd_take   = 1'b0;
        d.wr_stb    = 1'b0;
        d.wr_close  = 1'b0;
        // Codes sit in the lowest twelve lines only
        match   = grp_s[CEI_EQ_LSB +: CEI_EQ_W] == eq_num_i;
        sel_par = par_ok(grp_s[CEI_GRP_W:0]);
        ord_par = sel_par;

        // Order finished on the equipment side frees the lockout
        if (q.ord_lock && ord_done_i) begin
            d.ord_lock = 1'b0;
        end

        // Busy on transfer-active, deferred until ready
        if (q.attached && sy.act_lvl && ready_i) begin
            d.busy = 1'b1;
        end else if (!sy.act_lvl && !q.rd_xfer && !q.wr_xfer) begin
            d.busy = 1'b0;
        end

        // Input level: start only at a record boundary
        if (!sy.in_lvl) begin
            d.rd_xfer = 1'b0;
            if (q.rd_xfer) begin
                d.rec_skip = 1'b1;          // Medium runs on
            end
        end else if (q.attached && !q.rd_xfer && !q.rec_skip) begin
            d.rd_xfer = 1'b1;
        end
        if (rd_rec_end_i) begin
            d.rec_skip = 1'b0;              // Next record may be read
            if (q.rd_xfer) begin
                d.rec_end_pend = 1'b1;
            end
        end

        // Output level: each fall during an output transfer closes the record
        d.wr_xfer = q.attached && sy.out_lvl;
        if (sy.out_fall && q.wr_xfer) begin
            d.wr_close = 1'b1;
        end

        case (q.st)
            CEI_IDLE: begin
                if (sy.sel_rise) begin
                    d.pfault = 1'b0;        // Clear first
                    d.pf_out = 1'b0;
                    d.stat_gate = 1'b0;     // New code ends gating
                    d.cnt = '0;
                    if (!sel_par) begin
                        d.pfault   = 1'b1;
                        d.attached = 1'b0;
                    end else if (!match) begin
                        d.attached = 1'b0;  // Detach at once
                    end else begin
                        d.unit = grp_s[CEI_UNIT_W-1:0];
                        d.st   = CEI_SWAIT;
                    end
                end else if (sy.ord_rise && q.attached) begin
                    d.st = CEI_ANS;
                    if (!ord_par) begin
                        d.pfault = 1'b1;    // No execution
                        d.pf_out = 1'b1;
                        d.ans    = CEI_A_NONE;
                    end else if (ord_can_do_i &&
                                 (!q.ord_lock || ord_redo_i)) begin
                        d.ord_code  = grp_s[DW-1:0];
                        d.ord_start = 1'b1;
                        d.ord_lock  = 1'b1;
                        d.ans       = CEI_A_ACK;
                    end else begin
                        d.ans = CEI_A_REF;
                    end
                end else if (sy.wrd_rise && q.attached) begin
                    if (q.wr_xfer) begin
                        // Output: sample lines, then acknowledge
                        d.wr_word = grp_s[DW-1:0];
                        d.wr_stb  = 1'b1;
                        d.pf_out  = !ord_par;
                        d.pfault  = q.pfault | !ord_par;
                        d.ans     = CEI_A_ACK;
                        d.st      = CEI_ANS;
                    end else if (q.rec_end_pend) begin
                        d.rec_end_pend = 1'b0;
                        d.rd_xfer      = 1'b0;
                        d.ans  = CEI_A_REND;
                        d.st   = CEI_ANS;
                    end else if (q.rd_xfer) begin
                        d.st = CEI_WWAIT;
                    end
                end
            end
            CEI_SWAIT: begin
                // Hold off the answer for the least time
                if (!sy.sel_lvl) begin
                    d.st = CEI_IDLE;
                end else if (q.cnt == CEI_CNT_W'(CEI_HOLD_CYC - 1)) begin
                    d.st = CEI_ANS;
                    if (unavail_i) begin
                        d.ans       = CEI_A_REF;
                        d.stat_gate = 1'b1;
                    end else begin
                        d.ans       = CEI_A_ACK;
                        d.attached  = 1'b1;
                        d.stat_gate = 1'b1;
                    end
                end else begin
                    d.cnt = q.cnt + 1'b1;
                end
            end
            CEI_WWAIT: begin
                // Input: drive word, then acknowledge
                if (!sy.wrd_lvl || !q.rd_xfer) begin
                    d.st = CEI_IDLE;
                end else if (rd_valid_i) begin
                    d.dout    = rd_word_i;
                    d.pout    = par_gen(rd_word_i);
                    d.rd_take = 1'b1;
                    d.st      = CEI_ANS;
                    d.ans     = CEI_A_ACK;
                end
            end
            CEI_ANS: begin
                // Release once the answered strobe drops
                if (!sy.sel_lvl && !sy.ord_lvl && !sy.wrd_lvl) begin
                    d.ans    = CEI_A_NONE;
                    d.pf_out = 1'b0;
                    d.st     = CEI_IDLE;
                end
            end
            default: begin
                d.st = CEI_IDLE;
            end
        endcase

        // Drive data lines only during input
        d.oe     = q.attached && q.rd_xfer && !sy.sel_lvl && !sy.ord_lvl;
        d.status = dev_stat_i;
        d.status[CEI_BUSY_BIT]  = q.busy;
        d.status[CEI_READY_BIT] = ready_i;
        d.ans_hot = {d.ans == CEI_A_REND, d.ans == CEI_A_REF,
                     d.ans == CEI_A_ACK};
    end

    // ************************************************************
    // State register; reset is the global initialise
    // ************************************************************
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // Outputs straight from the state record
    // ************************************************************
    assign data_out_o          = q.dout;
    assign par_out_o           = q.pout;
    assign data_oe_o           = q.oe;
    assign ack_o               = q.ans_hot[0];
    assign refuse_o            = q.ans_hot[1];
    assign record_end_signal_o = q.ans_hot[2];
    assign par_fault_o         = q.pf_out;
    assign status_o            = q.status;
    assign status_oe_o         = q.stat_gate;
    assign ord_code_o          = q.ord_code;
    assign ord_start_o         = q.ord_start;
    assign unit_o              = q.unit;
    assign attached_o          = q.attached;
    assign link_pfault_o       = q.pfault;
    assign busy_o              = q.busy;
    assign rd_take_o           = q.rd_take;
    assign wr_word_o           = q.wr_word;
    assign wr_strobe_o         = q.wr_stb;
    assign wr_rec_close_o      = q.wr_close;
    assign rd_xfer_o           = q.rd_xfer;
endmodule

// *** cei_equipment_properties.sv ***
// Port checker for the channel equipment interface
`timescale 1ns/1ns
module cei_equipment_properties #(
    parameter int DW = 12                   // Data group width
) (
    // Clock, reset, channel side, ready and equipment number
    input wire logic          ref_clk_i, rstn_i, ready_i, par_in_i,
    input wire logic          sel_strobe_i, ord_strobe_i, wrd_strobe_i,
    input wire logic          act_level_i,
    input wire logic [DW-1:0] data_in_i,
    input wire logic [2:0]    eq_num_i,
    // Answers and state
    input wire logic          ack_o, refuse_o, record_end_signal_o,
    input wire logic          par_fault_o, ord_start_o, attached_o, busy_o
);
    // ****
    // Helpers
    // ****
    logic [15:0] sel_cnt_q;                 // Cycles select has been up
    wire ans = ack_o | refuse_o | record_end_signal_o;
    wire stb = sel_strobe_i | ord_strobe_i | wrd_strobe_i;
    wire bad = ~^{par_in_i, data_in_i};     // Even count of ones
    wire alien = data_in_i[11:9] != eq_num_i;
    // A counter keeps the 500-cycle hold-off out of long repetitions
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) sel_cnt_q <= 16'h0000;
        else sel_cnt_q <= sel_strobe_i ? sel_cnt_q + 16'h0001 : 16'h0000;
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    // ****
    // Properties
    // ****
    a_select_hold_off: assert property ((ack_o | refuse_o) &&
        sel_strobe_i |-> sel_cnt_q >= 16'h01F4) else $error("early answer");
    a_alien_silent: assert property (sel_strobe_i &&
        sel_cnt_q > 16'h0003 && (alien || bad) |-> !(ack_o | refuse_o))
        else $error("answer to foreign or faulty select");
    a_alien_detach: assert property ($rose(sel_strobe_i) && alien
        |-> ##[1:250] !attached_o) else $error("no detach");
    a_answer_release: assert property ($fell(stb)
        |-> ##[1:6] !ans) else $error("answer not released");
    a_answer_stands: assert property (ans && stb
        |=> $stable({ack_o, refuse_o, record_end_signal_o}))
        else $error("answer changed under strobe");
    a_bad_order_idle: assert property (ord_strobe_i && bad
        |-> !(ack_o | refuse_o | ord_start_o)) else $error("bad order run");
    a_bad_order_flag: assert property ($rose(ord_strobe_i) && bad &&
        attached_o |-> ##[3:8] par_fault_o) else $error("no fault signal");
    a_busy_on_active: assert property ($rose(act_level_i) &&
        ready_i && attached_o |-> ##[1:8] busy_o) else $error("not busy");
endmodule
bind cei_equipment cei_equipment_properties #(.DW(DW)) u_props (.ref_clk_i,
    .rstn_i, .ready_i, .par_in_i, .sel_strobe_i, .ord_strobe_i,
    .wrd_strobe_i, .act_level_i, .data_in_i, .eq_num_i, .ack_o, .refuse_o,
    .record_end_signal_o, .par_fault_o, .ord_start_o, .attached_o, .busy_o);

// *** cei_equipment_tb.sv ***
// Testbench for the channel equipment interface
`timescale 1ns/1ns
module cei_equipment_tb;
    // ****
    // Ports and bench state
    // ****
    logic ref_clk_i, rstn_i, sel_strobe_i, ord_strobe_i, wrd_strobe_i;
    logic in_level_i, out_level_i, act_level_i, par_in_i, par_out_o, cpar;
    logic data_oe_o, ack_o, refuse_o, record_end_signal_o, par_fault_o;
    logic status_oe_o, unavail_i, ready_i, ord_can_do_i, ord_redo_i;
    logic ord_done_i, rd_valid_i, rd_rec_end_i, ord_start_o, attached_o;
    logic link_pfault_o, busy_o, rd_take_o, wr_strobe_o, wr_rec_close_o;
    logic rd_xfer_o;
    logic [11:0] data_in_i, data_out_o, rd_word_i, dev_stat_i, status_o;
    logic [11:0] ord_code_o, wr_word_o, cdat, wr_last;
    logic [8:0]  unit_o;
    logic [3:0]  ans;
    logic [2:0]  eq_num_i, stb;
    logic [12:0] got;
    int          fail_count, comparisons, n_start, n_close, n_take;
    // The equipment's enable decides who sets the shared lines
    assign data_in_i = data_oe_o ? data_out_o : cdat;
    assign par_in_i = data_oe_o ? par_out_o : cpar;
    assign {wrd_strobe_i, ord_strobe_i, sel_strobe_i} = stb;
    cei_equipment dut (.ref_clk_i, .rstn_i, .sel_strobe_i, .ord_strobe_i,
        .wrd_strobe_i, .in_level_i, .out_level_i, .act_level_i, .data_in_i,
        .par_in_i, .data_out_o, .par_out_o, .data_oe_o, .ack_o, .refuse_o,
        .record_end_signal_o, .par_fault_o, .status_o, .status_oe_o,
        .eq_num_i, .unavail_i, .ready_i, .ord_can_do_i, .ord_redo_i,
        .ord_done_i, .rd_word_i, .rd_valid_i, .rd_rec_end_i, .dev_stat_i,
        .ord_code_o, .ord_start_o, .unit_o, .attached_o, .link_pfault_o,
        .busy_o, .rd_take_o, .wr_word_o, .wr_strobe_o, .wr_rec_close_o,
        .rd_xfer_o);
    cei_chan_model chan (.clk_i(ref_clk_i), .stb_o(stb), .dat_o(cdat),
        .par_o(cpar), .din_i({par_out_o, data_out_o}),
        .ans_i({par_fault_o, record_end_signal_o, refuse_o, ack_o}));
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    // Pulses are counted here so no scenario has to catch them in time
    always @(posedge ref_clk_i) begin
        if (ord_start_o === 1'b1) n_start++;
        if (wr_rec_close_o === 1'b1) n_close++;
        if (rd_take_o === 1'b1) n_take++;
        if (wr_strobe_o === 1'b1) wr_last = wr_word_o;
    end
    task automatic chk(input logic [19:0] s, input logic [19:0] e);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    // Selects may need the 500-cycle hold-off, the rest answer fast or not at all
    task automatic go(input int k, input logic [11:0] c, input logic b);
        chan.xfer(k, c, b, (k == 0) ? 600 : 50, ans, got);
    endtask
    // ****
    // Scenarios
    // ****
    task automatic s_connect;
        go(1, 12'h0C1, 1'b0);
        chk(ans, 4'h0);
        go(0, 12'hAA3, 1'b0);
        chk(ans, 4'h1);
        chk({attached_o, status_oe_o, unit_o}, 11'h6A3);
        chk(n_start, 16'h0000);
    endtask
    task automatic s_order;
        go(1, 12'h0C1, 1'b0);
        chk({ans, ord_code_o}, 16'h10C1);
        go(1, 12'h0C1, 1'b0);
        chk(ans, 4'h2);
        ord_done_i = 1'b1;
        ord_can_do_i = 1'b0;
        cyc(1);
        ord_done_i = 1'b0;
        go(1, 12'h0C2, 1'b0);
        chk(ans, 4'h2);
        ord_can_do_i = 1'b1;
        go(1, 12'h0C3, 1'b1);
        chk({ans, link_pfault_o}, 5'h11);
        chk(n_start, 16'h0001);
    endtask
    task automatic s_write;
        {out_level_i, act_level_i} = 2'b11;
        cyc(10);
        chk({busy_o, status_o[1]}, 2'b11);
        go(2, 12'h3C5, 1'b0);
        chk({ans, wr_last}, 16'h13C5);
        go(2, 12'h0F0, 1'b1);
        chk({ans, link_pfault_o, wr_last}, 17'h130F0);
        {out_level_i, act_level_i} = 2'b00;
        cyc(10);
        chk(n_close, 16'h0001);
    endtask
    task automatic s_read;
        {in_level_i, act_level_i, rd_valid_i} = 3'b111;
        cyc(10);
        go(2, 12'h000, 1'b0);
        chk({ans, got, n_take[1:0]}, 19'h0E971);
        rd_rec_end_i = 1'b1;
        cyc(1);
        rd_rec_end_i = 1'b0;
        go(2, 12'h000, 1'b0);
        chk(ans, 4'h4);
        {in_level_i, act_level_i, rd_valid_i} = 3'b000;
        cyc(4);                                         // Lines released
    endtask
    task automatic s_other;
        go(0, 12'h4A3, 1'b0);
        chk({ans, attached_o}, 5'h00);
        unavail_i = 1'b1;
        go(0, 12'hAA3, 1'b0);
        chk({ans, attached_o, status_oe_o}, 6'h09);
        {unavail_i, ready_i} = 2'b00;
        go(0, 12'hAA3, 1'b1);
        chk({ans, link_pfault_o}, 5'h01);
        go(0, 12'hAA3, 1'b0);
        chk({ans, link_pfault_o}, 5'h02);
        rstn_i = 1'b0;
        cyc(2);
        chk({attached_o, data_oe_o, ack_o}, 3'h0);
        rstn_i = 1'b1;
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        {rstn_i, in_level_i, out_level_i, act_level_i, unavail_i} = 5'h00;
        {ord_done_i, rd_valid_i, rd_rec_end_i, ord_redo_i} = 4'h0;
        {ready_i, ord_can_do_i, eq_num_i} = 5'h1D;
        {rd_word_i, dev_stat_i} = 24'hA5C840;
        {fail_count, comparisons, n_start, n_close, n_take} = '0;
        cyc(12);
        rstn_i = 1'b1;
        cyc(2);
        s_connect;
        s_order;
        s_write;
        s_read;
        s_other;
        wrap_up;
    end
    // About 3000 cycles are needed; the limit leaves ample room
    initial begin
        cyc(20000);
        fail_count++;
        wrap_up;
    end
endmodule

// *** cei_pkg.sv ***
// Package of constants and types for the channel equipment interface
package cei_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int CEI_GRP_W   = 12;        // One coded group on the lines
    localparam int CEI_EQ_W    = 3;         // Equipment number width
    localparam int CEI_UNIT_W  = 9;         // Unit field width
    localparam int CEI_EQ_LSB  = 9;         // Equipment field low bit
    localparam int CEI_STAT_W  = 12;        // Status lines
    localparam int CEI_BUSY_BIT  = 1;       // Busy status bit 01
    localparam int CEI_READY_BIT = 0;       // Ready status bit 00

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CEI_CLK_MHZ      = 250;  // Clock rate
    localparam int CEI_HOLD_US      = 2;    // Least wait before answer
    localparam int CEI_HOLD_CYC     = CEI_HOLD_US * CEI_CLK_MHZ;
    localparam int CEI_CNT_W        = 10;   // Hold counter width

    // ************************************************************
    // Handshake states
    // ************************************************************
    typedef enum logic [2:0] {
        CEI_IDLE  = 3'b000,                 // Waiting for a strobe
        CEI_SWAIT = 3'b001,                 // Select seen, holding off
        CEI_ANS   = 3'b010,                 // Answer held until drop
        CEI_WWAIT = 3'b011                  // Word strobe, awaiting data
    } cei_state_t;

    // Kind of answer held on the lines
    typedef enum logic [1:0] {
        CEI_A_NONE = 2'b00,
        CEI_A_ACK  = 2'b01,
        CEI_A_REF  = 2'b10,
        CEI_A_REND = 2'b11
    } cei_ans_t;

endpackage

// *** cei_sync.sv ***
// Two-stage synchronisers and edge detectors for channel levels
`timescale 1ns/1ns
module cei_sync (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    // Raw levels from the cable
    input  wire logic [5:0] raw_i,
    // Synchronised view
    cei_sync_if.prod  sy
);
    import cei_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [5:0] s1;                     // First stage, read by s2 only
        logic [5:0] s2;                     // Second stage
        logic [5:0] s3;                     // Delayed copy for edges
    } cei_sync_t;

    cei_sync_t st_q, st_d;

    // Shift the stages along
    always_comb begin
        st_d    = st_q;
        st_d.s1 = raw_i;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
    end

    // Register the state
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Edges are taken between second stage and its delayed copy
    assign sy.sel_lvl  = st_q.s2[0];
    assign sy.ord_lvl  = st_q.s2[1];
    assign sy.wrd_lvl  = st_q.s2[2];
    assign sy.in_lvl   = st_q.s2[3];
    assign sy.out_lvl  = st_q.s2[4];
    assign sy.act_lvl  = st_q.s2[5];
    assign sy.sel_rise = st_q.s2[0] & ~st_q.s3[0];
    assign sy.ord_rise = st_q.s2[1] & ~st_q.s3[1];
    assign sy.wrd_rise = st_q.s2[2] & ~st_q.s3[2];
    assign sy.act_rise = st_q.s2[5] & ~st_q.s3[5];
    assign sy.out_fall = ~st_q.s2[4] & st_q.s3[4];
endmodule

// *** cei_sync_if.sv ***
// Interface carrying synchronised channel levels and their edges
`timescale 1ns/1ns
interface cei_sync_if;
    logic sel_lvl;                          // Select strobe, synced
    logic ord_lvl;                          // Order strobe, synced
    logic wrd_lvl;                          // Word strobe, synced
    logic in_lvl;                           // Input level, synced
    logic out_lvl;                          // Output level, synced
    logic act_lvl;                          // Transfer-active, synced
    logic sel_rise;                         // Select strobe rising edge
    logic ord_rise;                         // Order strobe rising edge
    logic wrd_rise;                         // Word strobe rising edge
    logic act_rise;                         // Transfer-active rising edge
    logic out_fall;                         // Output level falling edge
    modport prod (output sel_lvl, ord_lvl, wrd_lvl, in_lvl, out_lvl,
                  act_lvl, sel_rise, ord_rise, wrd_rise, act_rise,
                  out_fall);
    modport cons (input sel_lvl, ord_lvl, wrd_lvl, in_lvl, out_lvl,
                  act_lvl, sel_rise, ord_rise, wrd_rise, act_rise,
                  out_fall);
endinterface
